/* rtl/usb_pkg.sv */
// package: register map, field positions and timing for the serial line block
package usb_pkg;
  localparam logic [3:0] USB_ADR_CTRL = 4'h0;
  localparam logic [3:0] USB_ADR_MODE = 4'h1;
  localparam logic [3:0] USB_ADR_STAT = 4'h2;
  localparam logic [3:0] USB_ADR_TXH = 4'h3;
  localparam logic [3:0] USB_ADR_RXH = 4'h4;
  localparam logic [3:0] USB_ADR_NERR = 4'h5;
  localparam logic [3:0] USB_ADR_BAUD = 4'h6;
  localparam logic [3:0] USB_ADR_TGRD = 4'h7;
  localparam logic [3:0] USB_ADR_DMA = 4'h8;
  // control bits
  localparam int USB_CR_RXEN = 4;
  localparam int USB_CR_RXDIS = 5;
  localparam int USB_CR_TXEN = 6;
  localparam int USB_CR_TXDIS = 7;
  localparam int USB_CR_STATUS_RESET_CMD = 8;
  localparam int USB_CR_START_BREAK_CMD = 9;
  localparam int USB_CR_STOP_BREAK_CMD = 10;
  // mode fields
  localparam int USB_MR_MODE_LSB = 0;
  localparam int USB_MR_CHAR_LENGTH_FIELD_LSB = 6;
  localparam int USB_MR_SYNC = 8;
  localparam int USB_MR_PAR_LSB = 9;
  localparam int USB_MR_NBSTOP = 12;
  localparam int USB_MR_MSB_FIRST_BIT = 16;
  localparam int USB_MR_NACK_INHIBIT_BIT = 20;
  localparam logic [3:0] USB_MODE_NORMAL = 4'h0;
  localparam logic [3:0] USB_MODE_HSHAKE = 4'h2;
  localparam logic [3:0] USB_MODE_T0 = 4'h4;
  localparam logic [3:0] USB_MODE_T1 = 4'h5;
  localparam logic [2:0] USB_PAR_EVEN = 3'h0;
  localparam logic [2:0] USB_PAR_ODD = 3'h1;
  localparam logic [2:0] USB_PAR_NONE = 3'h4;
  // status bits, then limits and timing
  localparam int USB_SR_RX_HOLDING_FULL_FLAG = 0;
  localparam int USB_SR_TX_HOLDING_FREE_FLAG = 1;
  localparam int USB_SR_RECEIVE_BREAK_FLAG = 2;
  localparam int USB_SR_FRAME = 6;
  localparam int USB_SR_PARITY_ERROR_FLAG = 7;
  localparam int USB_SR_TX_ALL_IDLE_FLAG = 9;
  localparam int USB_SR_CTS = 23;
  localparam logic [7:0] USB_NERR_MAX = 8'hFF;
  localparam logic [15:0] USB_BAUD_RST = 16'h0001;
  localparam logic [7:0] USB_BREAK_GAP = 8'h0C;
  localparam int USB_OVS = 16;
  localparam int USB_END_BRK_SMP = 2;
  localparam logic [3:0] USB_OVS_MID = 4'h7;
  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } usb_req_t;
  typedef enum logic [5:0] {
    USB_TX_IDLE = 6'h01,
    USB_TX_START = 6'h02,
    USB_TX_DATA = 6'h04,
    USB_TX_PAR = 6'h08,
    USB_TX_STOP = 6'h10,
    USB_TX_GAP = 6'h20
  } usb_tx_st_t;
  typedef enum logic [4:0] {
    USB_RX_IDLE = 5'h01,
    USB_RX_START = 5'h02,
    USB_RX_DATA = 5'h04,
    USB_RX_STOP = 5'h08,
    USB_RX_BRK = 5'h10
  } usb_rx_st_t;
endpackage

/* rtl/usb_line.sv */
// serial line block: framing, break, handshake and smart-card modes
// Operation
// - stop bit sampled low flags a framing error, except in T=0 mode
// - framing flag set mid stop bit, cleared by status reset write
// - break holds line low at least one character time
// - start break anytime, current character finishes, repeats ignored
// - early stop break still waits for minimum break length
// - break commands need transmit-ready; break start clears ready and empty
// - stop without start ignored; holding write during pending break ignored
// - after break line high 12 bit times or longer timeguard
// - all-zero character with low stop sets receive break, not framing
// - high of 2/16 bit, or one sample in sync mode, ends break and sets flag
// - mode value 0x2 selects hardware handshaking
// - rts high while receiver off or dma buffer complete
// - high cts stops transmitter after current character
// - mode 0x4 selects T=0, 0x5 selects T=1 smart card
// - smart card: data pin bidirectional, driven only when transmitting or sending a nack
// - smart card forces 8 data bits, even parity
// - inverse format complements data bits on the line
// - T=0 character ends in two-bit undriven guard time
// - T=0 parity error: one-bit low nack, character withheld, flag set
// - error counter saturates at 255, cleared on read
// - nack inhibit: no nack, character stored, receive ready rises
`timescale 1ns/1ns
`default_nettype none
module usb_line
  import usb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic sck_o,
  output logic rts_o,
  input wire logic cts_i,
  input wire logic dma_rx_done_i
);
  usb_req_t req;
  logic [31:0] mode_q, rdat_d;
  logic [15:0] baud_q, bdiv_q;
  logic [7:0] tgrd_q, nerr_q, txh_q, rxh_q, txsh_q, rxsh_q, gap_q;
  logic [3:0] tick_q, rtick_q;
  logic [3:0] tbit_q, rbit_q;
  logic os_tick, hit, wr, rd;
  logic rxen_q, txen_q, rx_holding_full_flag_q, tx_holding_free_flag_q, txbusy_q, frame_q, receive_break_flag_q, parity_error_flag_q;
  logic brk_pend_q, brk_on_q, brk_stop_q, brk_min_q, nack_q, sck_q, gap_brk_q;
  logic [3:0] mode_f;
  logic sc, t0, hs, inv, msb_first_bit, rx_in, par_bit, rx_par;
  logic [7:0] tx_bits;
  usb_tx_st_t tx_q;
  usb_rx_st_t rx_q;
  logic nack_drv_q;

  assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
  assign hit = cyc_i && stb_i && !ack_o;
  assign wr = hit && req.we && (req.sel == 4'hF);
  assign rd = hit && !req.we;
  assign mode_f = mode_q[USB_MR_MODE_LSB +: 4];
  // smart-card mode selection
  // card mode decode
  assign t0 = (mode_f == USB_MODE_T0);
  assign sc = t0 || (mode_f == USB_MODE_T1);
  assign hs = (mode_f == USB_MODE_HSHAKE);
  assign inv = sc && (mode_q[USB_MR_PAR_LSB +: 3] == USB_PAR_ODD);
  assign msb_first_bit = mode_q[USB_MR_MSB_FIRST_BIT];
  assign rx_in = sc ? (txd_oe_o ? txd_o : rxd_i) : rxd_i;
  assign os_tick = (bdiv_q == 16'h0000);
  assign tx_bits = inv ? ~txsh_q : txsh_q;
  assign par_bit = ^txsh_q;
  assign rx_par = ^rxsh_q;

  // baud oversampling divider, free running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bdiv_q <= 16'h0000;
      sck_q <= 1'b0;
    end else begin
      // reload with the divisor so one tick spans baud_q + 1 clocks
      bdiv_q <= os_tick ? baud_q : bdiv_q - 16'h0001;
      if (os_tick) begin
        sck_q <= sc ? ~sck_q : 1'b0;
      end
    end
  end

  // bus slave: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= hit;
      dat_o <= rd ? rdat_d : 32'h0000_0000;
    end
  end

  always_comb begin
    rdat_d = 32'h0000_0000;
    case (req.adr)
      USB_ADR_MODE: rdat_d = mode_q;
      USB_ADR_STAT: begin
        rdat_d[USB_SR_RX_HOLDING_FULL_FLAG] = rx_holding_full_flag_q;
        rdat_d[USB_SR_TX_HOLDING_FREE_FLAG] = tx_holding_free_flag_q;
        rdat_d[USB_SR_RECEIVE_BREAK_FLAG] = receive_break_flag_q;
        rdat_d[USB_SR_FRAME] = frame_q;
        rdat_d[USB_SR_PARITY_ERROR_FLAG] = parity_error_flag_q;
        rdat_d[USB_SR_TX_ALL_IDLE_FLAG] = tx_holding_free_flag_q && !txbusy_q;
        rdat_d[USB_SR_CTS] = cts_i;
      end
      USB_ADR_RXH: rdat_d = {24'h000000, rxh_q};
      USB_ADR_NERR: rdat_d = {24'h000000, nerr_q};
      USB_ADR_BAUD: rdat_d = {16'h0000, baud_q};
      USB_ADR_TGRD: rdat_d = {24'h000000, tgrd_q};
      default: rdat_d = 32'h0000_0000;
    endcase
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 32'h0000_0000;
      baud_q <= USB_BAUD_RST;
      tgrd_q <= 8'h00;
      rxen_q <= 1'b0;
      txen_q <= 1'b0;
    end else if (wr) begin
      if (req.adr == USB_ADR_MODE) mode_q <= req.dat;
      if (req.adr == USB_ADR_BAUD) baud_q <= req.dat[15:0];
      if (req.adr == USB_ADR_TGRD) tgrd_q <= req.dat[7:0];
      if (req.adr == USB_ADR_CTRL) begin
        if (req.dat[USB_CR_RXEN]) rxen_q <= 1'b1;
        if (req.dat[USB_CR_RXDIS]) rxen_q <= 1'b0;
        if (req.dat[USB_CR_TXEN]) txen_q <= 1'b1;
        if (req.dat[USB_CR_TXDIS]) txen_q <= 1'b0;
      end
    end
  end

  // rts from receiver enable and dma
  always_ff @(posedge clk_i) begin
    if (rst_i) rts_o <= 1'b1;
    else rts_o <= hs ? (!rxen_q || dma_rx_done_i) : 1'b0;
  end

  // transmitter: holding register, break control and shifter
  logic cr_wr, stt, stp;
  assign cr_wr = wr && (req.adr == USB_ADR_CTRL);
  assign stt = cr_wr && req.dat[USB_CR_START_BREAK_CMD] && tx_holding_free_flag_q && !brk_pend_q && !brk_on_q;
  assign stp = cr_wr && req.dat[USB_CR_STOP_BREAK_CMD] && tx_holding_free_flag_q && brk_on_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= USB_TX_IDLE;
      tx_holding_free_flag_q <= 1'b1;
      txbusy_q <= 1'b0;
      txh_q <= 8'h00;
      txsh_q <= 8'h00;
      tick_q <= 4'h0;
      tbit_q <= 4'h0;
      gap_q <= 8'h00;
      brk_pend_q <= 1'b0;
      brk_on_q <= 1'b0;
      brk_stop_q <= 1'b0;
      brk_min_q <= 1'b0;
      gap_brk_q <= 1'b0;
      txd_o <= 1'b1;
      txd_oe_o <= 1'b0;
    end else begin
      if (stt) brk_pend_q <= 1'b1;
      if (stp) brk_stop_q <= 1'b1;
      if (wr && req.adr == USB_ADR_TXH && tx_holding_free_flag_q && !brk_pend_q && !stt) begin
        txh_q <= req.dat[7:0];
        tx_holding_free_flag_q <= 1'b0;
      end
      if (os_tick) begin
        tick_q <= tick_q + 4'h1;
        case (tx_q)
          USB_TX_IDLE: begin
            txd_o <= 1'b1;
            txd_oe_o <= !sc;
            txbusy_q <= 1'b0;
            if (brk_pend_q) begin
              brk_pend_q <= 1'b0;
              brk_on_q <= 1'b1;
              brk_min_q <= 1'b0;
              // break start clears ready and empty
              tx_holding_free_flag_q <= 1'b0;
              txbusy_q <= 1'b1;
              txsh_q <= 8'h00;
              tx_q <= USB_TX_START;
              tick_q <= 4'h0;
            end else if (!tx_holding_free_flag_q && txen_q && !(hs && cts_i)) begin
              txsh_q <= txh_q;
              tx_holding_free_flag_q <= 1'b1;
              txbusy_q <= 1'b1;
              tx_q <= USB_TX_START;
              tick_q <= 4'h0;
            end
          end
          USB_TX_START: begin
            txd_o <= 1'b0;
            txd_oe_o <= 1'b1;
            if (tick_q == 4'hF) begin
              tx_q <= USB_TX_DATA;
              tbit_q <= 4'h0;
              // break left holding register, so stop can be taken
              if (brk_on_q) tx_holding_free_flag_q <= 1'b1;
            end
          end
          USB_TX_DATA: begin
            txd_o <= brk_on_q ? 1'b0 : (msb_first_bit ? tx_bits[7 - tbit_q[2:0]] : tx_bits[tbit_q[2:0]]);
            if (tick_q == 4'hF) begin
              tbit_q <= tbit_q + 4'h1;
              if (tbit_q == 4'h7) tx_q <= USB_TX_PAR;
            end
          end
          USB_TX_PAR: begin
            txd_o <= brk_on_q ? 1'b0 : (inv ? ~par_bit : par_bit);
            if (tick_q == 4'hF) begin
              tx_q <= USB_TX_STOP;
              tbit_q <= 4'h0;
            end
          end
          USB_TX_STOP: begin
            txd_o <= !brk_on_q;
            txd_oe_o <= !sc || brk_on_q;
            if (tick_q == 4'hF) begin
              tbit_q <= tbit_q + 4'h1;
              if (brk_on_q) begin
                // minimum break then wait for stop
                brk_min_q <= 1'b1;
                tbit_q <= 4'h0;
                if (brk_stop_q) begin
                  brk_on_q <= 1'b0;
                  brk_stop_q <= 1'b0;
                  gap_brk_q <= 1'b1;
                  gap_q <= 8'h00;
                  tx_q <= USB_TX_GAP;
                end
              end else if (tbit_q == (t0 ? 4'h1 : {3'h0, mode_q[USB_MR_NBSTOP]})) begin
                gap_brk_q <= 1'b0;
                gap_q <= 8'h00;
                tx_q <= USB_TX_GAP;
              end
            end
          end
          USB_TX_GAP: begin
            txd_o <= 1'b1;
            txd_oe_o <= !sc;
            if (tick_q == 4'hF) gap_q <= gap_q + 8'h01;
            if (!gap_brk_q || (gap_q >= USB_BREAK_GAP && gap_q >= tgrd_q)) begin
              tx_q <= USB_TX_IDLE;
            end
          end
          default: tx_q <= USB_TX_IDLE;
        endcase
      end
      // nack overrides the idle card line
      if (nack_drv_q) begin
        txd_o <= 1'b0;
        txd_oe_o <= 1'b1;
      end
    end
  end
  assign sck_o = sck_q;

  // receiver with oversampled bit centre and break tracking
  logic rx_s, nack_on;
  assign rx_s = rx_in;
  assign nack_on = t0 && !mode_q[USB_MR_NACK_INHIBIT_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_q <= USB_RX_IDLE;
      rtick_q <= 4'h0;
      rbit_q <= 4'h0;
      rxsh_q <= 8'h00;
      rxh_q <= 8'h00;
      rx_holding_full_flag_q <= 1'b0;
      frame_q <= 1'b0;
      receive_break_flag_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
      nerr_q <= 8'h00;
      nack_q <= 1'b0;
    end else begin
      if (cr_wr && req.dat[USB_CR_STATUS_RESET_CMD]) begin
        frame_q <= 1'b0;
        receive_break_flag_q <= 1'b0;
        parity_error_flag_q <= 1'b0;
      end
      if (rd && req.adr == USB_ADR_NERR) nerr_q <= 8'h00;
      if (rd && req.adr == USB_ADR_RXH) rx_holding_full_flag_q <= 1'b0;
      if (os_tick && rxen_q) begin
        rtick_q <= rtick_q + 4'h1;
        case (rx_q)
          USB_RX_IDLE: begin
            if (!rx_s) begin
              rx_q <= USB_RX_START;
              rtick_q <= 4'h0;
            end
          end
          USB_RX_START: begin
            if (rtick_q == USB_OVS_MID) begin
              rx_q <= rx_s ? USB_RX_IDLE : USB_RX_DATA;
              rtick_q <= 4'h8;
              rbit_q <= 4'h0;
            end
          end
          USB_RX_DATA: begin
            if (rtick_q == USB_OVS_MID) begin
              rbit_q <= rbit_q + 4'h1;
              if (rbit_q < 4'h8) begin
                if (msb_first_bit) rxsh_q <= {rxsh_q[6:0], rx_s ^ inv};
                else rxsh_q <= {rx_s ^ inv, rxsh_q[7:1]};
              end else begin
                nack_q <= (rx_par ^ rx_s ^ inv);
                rx_q <= USB_RX_STOP;
              end
            end
          end
          USB_RX_STOP: begin
            if (rtick_q == USB_OVS_MID) begin
              rx_q <= USB_RX_IDLE;
              if (!rx_s && rxsh_q == 8'h00 && !nack_q) begin
                receive_break_flag_q <= 1'b1;
                rx_q <= USB_RX_BRK;
              end else if (!rx_s && !t0) begin
                frame_q <= 1'b1;
              end else if (nack_q && sc) begin
                parity_error_flag_q <= 1'b1;
                if (nerr_q != USB_NERR_MAX) nerr_q <= nerr_q + 8'h01;
                if (!nack_on) begin
                  rxh_q <= rxsh_q;
                  rx_holding_full_flag_q <= 1'b1;
                end
              end else begin
                rxh_q <= rxsh_q;
                rx_holding_full_flag_q <= 1'b1;
              end
            end
          end
          USB_RX_BRK: begin
            if (!rx_s) rtick_q <= 4'h0;
            else if (mode_q[USB_MR_SYNC] || rtick_q == 4'(USB_END_BRK_SMP - 1)) begin
              receive_break_flag_q <= 1'b1;
              rx_q <= USB_RX_IDLE;
            end
          end
          default: rx_q <= USB_RX_IDLE;
        endcase
      end
    end
  end

  // nack driven on the shared line; transmitter is off by software contract
  logic [4:0] nack_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nack_drv_q <= 1'b0;
      nack_cnt_q <= 5'h00;
    end else if (os_tick) begin
      if (rx_q == USB_RX_STOP && rtick_q == 4'h8 && nack_q && nack_on) begin
        nack_drv_q <= 1'b1;
        nack_cnt_q <= 5'h00;
      end else if (nack_drv_q) begin
        nack_cnt_q <= nack_cnt_q + 5'h01;
        if (nack_cnt_q == 5'(USB_OVS - 1)) nack_drv_q <= 1'b0;
      end
    end
  end
  // framing flag only rises on a low stop
  frame_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(frame_q) |-> $past(rx_q) == USB_RX_STOP && !$past(rx_s))
    else $error("framing flag without low stop");
  frame_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_q && !(cr_wr && req.dat[USB_CR_STATUS_RESET_CMD]) |=> frame_q)
    else $error("framing flag lost");
  brk_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    brk_on_q && cr_wr && req.dat[USB_CR_START_BREAK_CMD] |=> !brk_pend_q)
    else $error("break restarted");
  brk_rdy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    os_tick && tx_q == USB_TX_IDLE && brk_pend_q |=> !tx_holding_free_flag_q && brk_on_q)
    else $error("break start mishandled");
  brk_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !brk_on_q |-> !stp)
    else $error("stop without break");
  rts_hs_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hs && !rxen_q ##1 hs |-> rts_o)
    else $error("rts low with receiver off");
  nerr_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    nerr_q == USB_NERR_MAX && !rd |=> nerr_q == USB_NERR_MAX)
    else $error("error count wrapped");
  brk_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    brk_on_q && tx_q == USB_TX_DATA |=> !txd_o)
    else $error("break line high");
endmodule
`default_nettype wire

/* tb/usb_remote.sv */
// far-side model: remote serial sender with flow-control pins
`timescale 1ns/1ns
`default_nettype none
module usb_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  output logic line_o,
  output logic cts_o,
  output logic dma_done_o
);
  initial begin
    line_o = 1'b1;
    cts_o = 1'b0;
    dma_done_o = 1'b0;
  end
  // lsb first; line left at the last bit so a break can be stretched
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      line_o <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge clk_i);
    end
  endtask
  // released line goes to the pull-up level
  task automatic release_line();
    @(posedge clk_i);
    line_o <= 1'b1;
  endtask
  task automatic set_flow(input logic cts, input logic done);
    @(posedge clk_i);
    cts_o <= cts;
    dma_done_o <= done;
  endtask
endmodule
`default_nettype wire

/* tb/usb_line_tb.sv */
// testbench: framing, break, handshake and smart-card checks
`timescale 1ns/1ns
`default_nettype none
module usb_line_tb;
  import usb_pkg::*;
  localparam int BITC = 32;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack_o, txd_o, txd_oe_o, sck_o, rts_o, rem_line, cts, dma_done;
  int fails = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  int drv_low = 0;
  // cycles in which the block itself pulls its line low
  always @(posedge clk_i) begin
    if (txd_oe_o === 1'b1 && txd_o === 1'b0) drv_low <= drv_low + 1;
  end
  // shared card line: pull-up, either party pulls low
  wire logic line = rem_line & (txd_oe_o ? txd_o : 1'b1);
  usb_line i_usb_line (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .rxd_i(line),
    .txd_o(txd_o), .txd_oe_o(txd_oe_o), .sck_o(sck_o), .rts_o(rts_o), .cts_i(cts),
    .dma_rx_done_i(dma_done));
  usb_remote #(.BIT_CLKS(BITC)) i_usb_remote (.clk_i(clk_i), .line_o(rem_line),
    .cts_o(cts), .dma_done_o(dma_done));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      fails = fails + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // classic cycle: hold until ack sampled high, then one idle cycle
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 64);
    if (n >= 64) chk("bus ack", 32'h1, 32'h0);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic stat(input int b, input logic exp, input string what);
    wb(USB_ADR_STAT, 1'b0, 32'h0);
    chk(what, {31'h0, exp}, {31'h0, rd[b]});
  endtask
  task automatic wait_txd(input logic v, input int lim, output int n);
    n = 0;
    while (txd_o !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic t_reset();
    chk("idle line", 32'h1, {31'h0, txd_o});
    chk("idle drive", 32'h0, {31'h0, txd_oe_o});
    wb(4'hF, 1'b0, 32'h0);
    chk("unmapped read", 32'h0, rd);
  endtask
  task automatic t_rx();
    wb(USB_ADR_MODE, 1'b1, 32'h000008C0);
    wb(USB_ADR_CTRL, 1'b1, 32'h00000010);
    // start, data, even parity, low stop
    i_usb_remote.send({1'b0, 1'b0, 8'hA5, 1'b0}, 11);
    stat(USB_SR_FRAME, 1'b1, "framing set");
    i_usb_remote.release_line();
    // the low tail starts one more character; let it finish
    repeat (12 * BITC) @(posedge clk_i);
    wb(USB_ADR_CTRL, 1'b1, 32'h00000100);
    stat(USB_SR_FRAME, 1'b0, "framing cleared");
    // all-zero character, line held low past the stop bit
    i_usb_remote.send(11'h000, 11);
    stat(USB_SR_RECEIVE_BREAK_FLAG, 1'b1, "break seen");
    stat(USB_SR_FRAME, 1'b0, "break no framing");
    wb(USB_ADR_CTRL, 1'b1, 32'h00000100);
    stat(USB_SR_RECEIVE_BREAK_FLAG, 1'b0, "break cleared");
    i_usb_remote.release_line();
    repeat (BITC) @(posedge clk_i);
    stat(USB_SR_RECEIVE_BREAK_FLAG, 1'b1, "break end");
  endtask
  task automatic t_txbrk();
    int n, t0, k;
    wb(USB_ADR_CTRL, 1'b1, 32'h00000040);
    // all-ones character, then break while it shifts out
    wb(USB_ADR_TXH, 1'b1, 32'h000000FF);
    wb(USB_ADR_CTRL, 1'b1, 32'h00000200);
    wait_txd(1'b0, 200, n);
    wait_txd(1'b1, 2 * BITC, n);
    chk("char before break", 32'h1, {31'h0, n < 2 * BITC});
    // the parity bit of the character is low too; a break is a long low run
    k = 0;
    n = 0;
    while (k < 2 * BITC && n < 40 * BITC) begin
      @(posedge clk_i);
      n++;
      k = (txd_o === 1'b0) ? k + 1 : 0;
    end
    chk("break seen", 32'h1, {31'h0, k >= 2 * BITC});
    t0 = cyc_cnt - k;
    stat(USB_SR_TX_ALL_IDLE_FLAG, 1'b0, "empty on break");
    k = 0;
    do begin
      wb(USB_ADR_STAT, 1'b0, 32'h0);
      k++;
    end while (rd[USB_SR_TX_HOLDING_FREE_FLAG] !== 1'b1 && k < 40);
    // stop issued alone, well before one character has passed
    wb(USB_ADR_CTRL, 1'b1, 32'h00000400);
    wait_txd(1'b1, 40 * BITC, n);
    chk("break length", 32'h1, {31'h0, cyc_cnt - t0 >= 10 * BITC});
    t0 = cyc_cnt;
    wb(USB_ADR_TXH, 1'b1, 32'h0000005A);
    wait_txd(1'b0, 40 * BITC, n);
    chk("gap after break", 32'h1, {31'h0, cyc_cnt - t0 >= 12 * BITC});
    repeat (12 * BITC) @(posedge clk_i);
  endtask
  task automatic t_hshake();
    int n;
    wb(USB_ADR_MODE, 1'b1, 32'h000008C2);
    wb(USB_ADR_CTRL, 1'b1, 32'h00000020);
    repeat (4) @(posedge clk_i);
    chk("rts rx off", 32'h1, {31'h0, rts_o});
    wb(USB_ADR_CTRL, 1'b1, 32'h00000010);
    repeat (4) @(posedge clk_i);
    chk("rts rx on", 32'h0, {31'h0, rts_o});
    i_usb_remote.set_flow(1'b0, 1'b1);
    repeat (4) @(posedge clk_i);
    chk("rts dma done", 32'h1, {31'h0, rts_o});
    i_usb_remote.set_flow(1'b1, 1'b0);
    repeat (4) @(posedge clk_i);
    chk("rts new buffer", 32'h0, {31'h0, rts_o});
    wb(USB_ADR_TXH, 1'b1, 32'h00000033);
    wait_txd(1'b0, 300, n);
    chk("cts hold", 32'd300, n);
    i_usb_remote.set_flow(1'b0, 1'b0);
    wait_txd(1'b0, 2 * BITC, n);
    chk("cts release", 32'h1, {31'h0, n < 2 * BITC});
    repeat (12 * BITC) @(posedge clk_i);
  endtask
  task automatic t_card();
    logic s0, tog;
    int n, base;
    wb(USB_ADR_CTRL, 1'b1, 32'h000000A0);
    for (int m = 4; m < 6; m++) begin
      wb(USB_ADR_MODE, 1'b1, 32'(m));
      s0 = sck_o;
      tog = 1'b0;
      repeat (8) begin
        @(posedge clk_i);
        tog = tog | (sck_o !== s0);
      end
      chk("card clock", 32'h1, {31'h0, tog});
    end
    wb(USB_ADR_MODE, 1'b1, 32'h00000004);
    // receiver alone in card mode
    wb(USB_ADR_CTRL, 1'b1, 32'h00000110);
    wb(USB_ADR_NERR, 1'b0, 32'h0);
    wb(USB_ADR_RXH, 1'b0, 32'h0);
    base = drv_low;
    i_usb_remote.send({1'b1, 8'hC3, 1'b0}, 10);
    i_usb_remote.release_line();
    repeat (3 * BITC) @(posedge clk_i);
    chk("nack length", 32'h1, {31'h0, drv_low - base >= BITC - 4 && drv_low - base <= BITC + 4});
    stat(USB_SR_PARITY_ERROR_FLAG, 1'b1, "parity flag");
    stat(USB_SR_RX_HOLDING_FULL_FLAG, 1'b0, "char withheld");
    wb(USB_ADR_NERR, 1'b0, 32'h0);
    chk("error count", 32'h1, {24'h0, rd[7:0]});
    wb(USB_ADR_NERR, 1'b0, 32'h0);
    chk("count cleared", 32'h0, {24'h0, rd[7:0]});
    wb(USB_ADR_MODE, 1'b1, 32'h00100004);
    wb(USB_ADR_CTRL, 1'b1, 32'h00000100);
    base = drv_low;
    i_usb_remote.send({1'b1, 8'hC3, 1'b0}, 10);
    i_usb_remote.release_line();
    repeat (3 * BITC) @(posedge clk_i);
    chk("inhibit no nack", 32'h0, drv_low - base);
    stat(USB_SR_RX_HOLDING_FULL_FLAG, 1'b1, "inhibit ready");
    wb(USB_ADR_RXH, 1'b0, 32'h0);
    chk("inhibit data", 32'h000000C3, {24'h0, rd[7:0]});
    // transmitter alone in card mode
    wb(USB_ADR_CTRL, 1'b1, 32'h00000060);
    chk("undriven idle", 32'h0, {31'h0, txd_oe_o});
    wb(USB_ADR_TXH, 1'b1, 32'h0000003C);
    n = 0;
    while (txd_oe_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (txd_oe_o === 1'b1 && n < 40 * BITC) begin
      @(posedge clk_i);
      n++;
    end
    chk("drive span", 32'h1, {31'h0, n >= 10 * BITC - 4 && n <= 10 * BITC + 4});
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rx();
    t_txbrk();
    t_hshake();
    t_card();
    summarize();
  end
endmodule
`default_nettype wire
